//--- rtl/pid_reg_defs.svh
// Offsets, codes, scaling and timing constants of the process regulator
`ifndef PID_REG_DEFS_SVH
`define PID_REG_DEFS_SVH

// ----------------------------------------
// Serial register offsets and setpoint select bit
// ----------------------------------------
`define SER_SETPOINT_OFS   8'h06
`define SER_SOURCE_OFS     8'h0F
`define PID_MON_OFS        8'h40
`define SER_SP_SEL_BIT     1

// ----------------------------------------
// Function modes and source codes
// ----------------------------------------
`define MODE_OFF           3'h0
`define MODE_DIRECT_DEV    3'h1
`define MODE_DIRECT_FB     3'h2
`define MODE_TRIM_DEV      3'h3
`define MODE_TRIM_FB       3'h4
`define FN_SETPOINT        8'h0C
`define FN_FEEDBACK        8'h0B
`define FN_DIFF_FB         8'h16
`define PULSE_SETPOINT     8'h02
`define PULSE_FEEDBACK     8'h01

// ----------------------------------------
// Scaling and timing
// ----------------------------------------
`define CLK_FREQ_MHZ       25
`define SAMPLE_TIME_US     1000
`define GAIN_SCALE         64'sh64
`define TI_UNIT_US         64'sh186A0
`define TD_UNIT_US         64'sh2710
`define ILIM_TO_PCT        64'shA

`endif

//--- rtl/pid_regulator_pkg.sv
// Types shared by the process regulator
package pid_regulator_pkg;

    // Configuration parameters from the drive parameter store
    typedef struct packed {
        logic        [2:0]  mode;
        logic        [11:0] kp;
        logic        [11:0] ti;
        logic        [9:0]  ilim;
        logic        [9:0]  td;
        logic               sp_param_sel;
        logic signed [15:0] sp_param_val;
        logic        [7:0]  ain1_fn;
        logic        [7:0]  ain2_fn;
        logic        [7:0]  pulse_fn;
    } pid_cfg_s;

    // Whole state of the regulator
    typedef struct packed {
        logic        [23:0] ctr;
        logic               tick;
        logic        [2:0]  mode;
        logic signed [47:0] acc;
        logic signed [17:0] dprev;
        logic signed [15:0] pid_out;
        logic signed [15:0] freq_out;
        logic               cfg_err;
        logic               diff_act;
        logic        [15:0] ser_sp;
        logic        [15:0] ser_sel;
        logic        [15:0] rdata;
    } pid_state_s;

endpackage : pid_regulator_pkg

//--- rtl/pid_process_regulator.sv
// Closed-loop PID regulator with source selection and conflict alarm
`timescale 1ns/1ps
`include "pid_reg_defs.svh"

module pid_process_regulator
    import pid_regulator_pkg::*;
#(
    parameter int SAMPLE_US = `SAMPLE_TIME_US
)(
    // Clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               reset_n_i,
    // Parameters
    input  wire pid_cfg_s           cfg_i,
    // Process signals, 0.01 percent units
    input  wire logic signed [15:0] freq_reference_i,
    input  wire logic signed [15:0] analog_input_one_i,
    input  wire logic signed [15:0] analog_input_two_i,
    input  wire logic signed [15:0] pulse_train_input_i,
    // Serial register port
    input  wire logic               ser_wr_i,
    input  wire logic        [7:0]  ser_addr_i,
    input  wire logic        [15:0] ser_wdata_i,
    output logic             [15:0] ser_rdata_o,
    // Results
    output logic signed      [15:0] pid_output_o,
    output logic signed      [15:0] freq_output_o,
    output logic                    sample_done_o,
    output logic                    operator_config_error_o,
    output logic                    diff_feedback_active_o
);

    // ----------------------------------------
    // Constants and helpers
    // ----------------------------------------
    localparam int          SAMPLE_CYCLES = SAMPLE_US * `CLK_FREQ_MHZ;
    localparam logic [23:0] LAST_CYCLE    = 24'(SAMPLE_CYCLES - 1);
    localparam logic signed [63:0] SAMPLE_US_S = 64'(SAMPLE_US);

    function automatic logic signed [15:0] sat16(input logic signed [63:0] v);
        if (v > 64'sh7FFF)
            return 16'sh7FFF;
        else if (v < -64'sh8000)
            return 16'sh8000;
        else
            return v[15:0];
    endfunction : sat16

    pid_state_s         st_q;
    pid_state_s         st_d;
    logic               tick_c;
    logic               en_c;
    logic [4:0]         sp_src;
    logic [2:0]         fb_src;
    logic [1:0]         dfb_src;
    logic signed [15:0] sp_v;
    logic signed [15:0] fb_v;
    logic signed [15:0] dfb_v;
    logic signed [63:0] kp_s;
    logic signed [63:0] ti_s;
    logic signed [63:0] td_s;
    logic signed [63:0] il_s;
    logic signed [63:0] dev;
    logic signed [63:0] din;
    logic signed [63:0] dterm;
    logic signed [63:0] pin;
    logic signed [63:0] pterm;
    logic signed [63:0] iterm;
    logic signed [63:0] acc_n;
    logic signed [63:0] acc_lim;
    logic signed [15:0] pid_n;

    // ----------------------------------------
    // Source decode and conflicts
    // ----------------------------------------
    always_comb
    begin
        sp_src  = {cfg_i.pulse_fn == `PULSE_SETPOINT,
                   cfg_i.ain2_fn == `FN_SETPOINT,
                   cfg_i.ain1_fn == `FN_SETPOINT,
                   st_q.ser_sel[`SER_SP_SEL_BIT],
                   cfg_i.sp_param_sel};
        fb_src  = {cfg_i.pulse_fn == `PULSE_FEEDBACK,
                   cfg_i.ain2_fn == `FN_FEEDBACK,
                   cfg_i.ain1_fn == `FN_FEEDBACK};
        dfb_src = {cfg_i.ain2_fn == `FN_DIFF_FB, cfg_i.ain1_fn == `FN_DIFF_FB};
        en_c    = (cfg_i.mode != `MODE_OFF) && (cfg_i.mode <= `MODE_TRIM_FB);
        tick_c  = (st_q.ctr == LAST_CYCLE);
        // Setpoint selection
        if ((cfg_i.mode == `MODE_DIRECT_DEV) || (cfg_i.mode == `MODE_DIRECT_FB))
            sp_v = freq_reference_i;
        else if (sp_src[1])
            sp_v = st_q.ser_sp;
        else if (sp_src[0])
            sp_v = cfg_i.sp_param_val;
        else if (sp_src[2])
            sp_v = analog_input_one_i;
        else if (sp_src[3])
            sp_v = analog_input_two_i;
        else if (sp_src[4])
            sp_v = pulse_train_input_i;
        else
            sp_v = 16'sh0000;
        // Feedback selection
        if (fb_src[0])
            fb_v = analog_input_one_i;
        else if (fb_src[1])
            fb_v = analog_input_two_i;
        else if (fb_src[2])
            fb_v = pulse_train_input_i;
        else
            fb_v = 16'sh0000;
        if (dfb_src[0])
            dfb_v = analog_input_one_i;
        else if (dfb_src[1])
            dfb_v = analog_input_two_i;
        else
            dfb_v = 16'sh0000;
    end

    // ----------------------------------------
    // Regulator arithmetic
    // ----------------------------------------
    always_comb
    begin
        kp_s  = 64'($signed({1'b0, cfg_i.kp}));
        ti_s  = 64'($signed({1'b0, cfg_i.ti}));
        td_s  = 64'($signed({1'b0, cfg_i.td}));
        il_s  = 64'($signed({1'b0, cfg_i.ilim}));
        dev   = 64'(sp_v) - 64'(fb_v);
        if (|dfb_src)
            dev = dev + 64'(dfb_v);
        if ((cfg_i.mode == `MODE_DIRECT_FB) || (cfg_i.mode == `MODE_TRIM_FB))
            din = dev - 64'(sp_v);
        else
            din = dev;
        dterm = (din - 64'(st_q.dprev)) * td_s * `TD_UNIT_US / SAMPLE_US_S;
        pin   = dev + dterm;
        pterm = pin * kp_s / `GAIN_SCALE;
        acc_lim = il_s * `ILIM_TO_PCT * ti_s * `TI_UNIT_US;
        acc_n   = 64'(st_q.acc) + pin * SAMPLE_US_S;
        if (acc_n > acc_lim)
            acc_n = acc_lim;
        else if (acc_n < -acc_lim)
            acc_n = -acc_lim;
        if (cfg_i.ti == 12'h000)
        begin
            acc_n = 64'sh0;
            iterm = 64'sh0;
        end
        else
            iterm = acc_n / (ti_s * `TI_UNIT_US);
        pid_n = sat16(pterm + iterm);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        st_d       = st_q;
        st_d.ctr   = tick_c ? 24'h000000 : st_q.ctr + 24'h000001;
        st_d.tick  = tick_c;
        st_d.cfg_err  = ($countones(sp_src) > 1) ||
                        ($countones(fb_src) > 1) ||
                        ($countones(dfb_src) > 1) ||
                        (cfg_i.mode > `MODE_TRIM_FB);
        st_d.diff_act = |dfb_src;
        if (ser_wr_i && (ser_addr_i == `SER_SETPOINT_OFS))
            st_d.ser_sp = ser_wdata_i;
        if (ser_wr_i && (ser_addr_i == `SER_SOURCE_OFS))
            st_d.ser_sel = ser_wdata_i;
        case (ser_addr_i)
            `SER_SETPOINT_OFS: st_d.rdata = st_q.ser_sp;
            `SER_SOURCE_OFS:   st_d.rdata = st_q.ser_sel;
            `PID_MON_OFS:      st_d.rdata = st_q.pid_out;
            default:           st_d.rdata = 16'h0000;
        endcase
        if (tick_c)
        begin
            st_d.mode = cfg_i.mode;
            if (en_c)
            begin
                st_d.acc     = acc_n[47:0];
                st_d.dprev   = (cfg_i.td == 10'h000) ? 18'sh00000 : din[17:0];
                st_d.pid_out = pid_n;
                if (cfg_i.mode <= `MODE_DIRECT_FB)
                    st_d.freq_out = pid_n;
                else
                    st_d.freq_out = sat16(64'(freq_reference_i) + 64'(pid_n));
            end
            else
            begin
                st_d.acc      = 48'sh0;
                st_d.dprev    = 18'sh00000;
                st_d.pid_out  = 16'sh0000;
                st_d.freq_out = freq_reference_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign ser_rdata_o             = st_q.rdata;
    assign pid_output_o            = st_q.pid_out;
    assign freq_output_o           = st_q.freq_out;
    assign sample_done_o           = st_q.tick;
    assign operator_config_error_o = st_q.cfg_err;
    assign diff_feedback_active_o  = st_q.diff_act;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    AST_SP_CONFLICT: assert property ($countones(sp_src) > 1 |=> st_q.cfg_err)
        else $error("setpoint conflict not flagged");
    AST_FB_CONFLICT: assert property ($countones(fb_src) > 1 |=> st_q.cfg_err)
        else $error("feedback conflict not flagged");
    AST_DFB_CONFLICT: assert property (dfb_src == 2'b11 |=> st_q.cfg_err)
        else $error("differential conflict not flagged");
    AST_NO_CONFLICT: assert property ($countones(sp_src) <= 1 && $countones(fb_src) <= 1 && dfb_src != 2'b11
        && cfg_i.mode <= `MODE_TRIM_FB |=> !st_q.cfg_err)
        else $error("spurious configuration error");
    AST_DIFF_ACTIVE: assert property (|dfb_src |=> st_q.diff_act)
        else $error("differential feedback not active");
    AST_TICK_SPACING: assert property (st_q.tick |=> (!st_q.tick) [*8])
        else $error("sample ticks too close");
    AST_DISABLED_CLEAR: assert property (tick_c && !en_c |=> st_q.acc == 48'sh0 && st_q.dprev == 18'sh00000
        && st_q.pid_out == 16'sh0000 && st_q.freq_out == $past(freq_reference_i))
        else $error("disabled regulator not cleared");
    AST_NO_INTEGRAL: assert property (tick_c && en_c && cfg_i.ti == 12'h000 |=> st_q.acc == 48'sh0)
        else $error("integral active with zero time");
    AST_DIRECT_OUT: assert property (tick_c && (cfg_i.mode == `MODE_DIRECT_DEV || cfg_i.mode == `MODE_DIRECT_FB)
        |=> st_q.freq_out == st_q.pid_out)
        else $error("direct mode output mismatch");
    AST_TRIM_ZERO: assert property (tick_c && cfg_i.mode == `MODE_TRIM_DEV && cfg_i.kp == 12'h000
        && cfg_i.ti == 12'h000 |=> st_q.freq_out == $past(freq_reference_i))
        else $error("trim mode with zero gains changed reference");
    AST_SER_WRITE: assert property (ser_wr_i && ser_addr_i == `SER_SETPOINT_OFS
        |=> st_q.ser_sp == $past(ser_wdata_i))
        else $error("serial setpoint not stored");

    // ----------------------------------------
    // Source selection checks
    // ----------------------------------------
    AST_SETPOINT_REF: assert property (tick_c && cfg_i.mode inside {`MODE_DIRECT_DEV, `MODE_DIRECT_FB}
        |-> sp_v == freq_reference_i)
        else $error("reference not used as setpoint");
    AST_SETPOINT_SER: assert property (tick_c && cfg_i.mode >= `MODE_TRIM_DEV
        && st_q.ser_sel[`SER_SP_SEL_BIT] |-> sp_v == $signed(st_q.ser_sp))
        else $error("serial setpoint not selected");
    AST_SETPOINT_PARAM: assert property (tick_c && cfg_i.mode >= `MODE_TRIM_DEV
        && sp_src == 5'b00001 |-> sp_v == cfg_i.sp_param_val)
        else $error("stored setpoint not selected");
    AST_SETPOINT_ANA: assert property (tick_c && cfg_i.mode >= `MODE_TRIM_DEV
        && sp_src inside {5'b00100, 5'b01000, 5'b10000}
        |-> sp_v == (sp_src[2] ? analog_input_one_i : sp_src[3] ? analog_input_two_i : pulse_train_input_i))
        else $error("input setpoint not selected");
    AST_SETPOINT_NONE: assert property (tick_c && cfg_i.mode >= `MODE_TRIM_DEV && sp_src == 5'b00000
        |-> sp_v == 16'sh0000)
        else $error("unassigned setpoint not zero");
    AST_FEEDBACK_SEL: assert property (fb_src inside {3'b001, 3'b010, 3'b100}
        |-> fb_v == (fb_src[0] ? analog_input_one_i : fb_src[1] ? analog_input_two_i : pulse_train_input_i))
        else $error("feedback input not selected");
    AST_DIFF_INACTIVE: assert property (dfb_src == 2'b00 |=> !st_q.diff_act)
        else $error("differential feedback active without source");

    // ----------------------------------------
    // Arithmetic checks
    // ----------------------------------------
    AST_UNIT_GAIN: assert property (tick_c && cfg_i.mode == `MODE_DIRECT_DEV && dfb_src == 2'b00
        && cfg_i.kp == 12'h064 && cfg_i.ti == 12'h000 && cfg_i.td == 10'h000
        |=> st_q.pid_out == sat16(64'($past(freq_reference_i)) - 64'($past(fb_v))))
        else $error("unit gain output differs from deviation");
    AST_DIFF_VALUE: assert property (tick_c && cfg_i.mode == `MODE_TRIM_DEV && dfb_src == 2'b10
        && fb_src == 3'b001 && sp_src == 5'b00000 && cfg_i.kp == 12'h064
        && cfg_i.ti == 12'h000 && cfg_i.td == 10'h000
        |=> st_q.pid_out == sat16(64'($past(analog_input_two_i)) - 64'($past(analog_input_one_i))))
        else $error("differential process value wrong");
    AST_TRIM_SUM: assert property (tick_c && cfg_i.mode inside {`MODE_TRIM_DEV, `MODE_TRIM_FB}
        |=> 17'(st_q.freq_out) == 17'($past(freq_reference_i)) + 17'(st_q.pid_out)
            || st_q.freq_out == 16'sh7FFF || st_q.freq_out == 16'sh8000)
        else $error("trim output is not reference plus PID");
    AST_MODE_OFF_OUT: assert property (st_q.tick && st_q.mode == `MODE_OFF
        |-> st_q.pid_out == 16'sh0000 && st_q.freq_out == $past(freq_reference_i))
        else $error("disabled regulator did not pass the reference");
    AST_DERIV_OFF: assert property (tick_c && en_c && cfg_i.td == 10'h000 |=> st_q.dprev == 18'sh00000)
        else $error("derivative history kept with zero time");
    AST_INT_CLAMP: assert property (tick_c && en_c && cfg_i.ti != 12'h000
        |=> 64'(st_q.acc) <= $past(acc_lim) && 64'(st_q.acc) >= -$past(acc_lim))
        else $error("integral accumulator beyond limit");

    // ----------------------------------------
    // Serial and timing checks
    // ----------------------------------------
    AST_SER_SOURCE: assert property (ser_wr_i && ser_addr_i == `SER_SOURCE_OFS
        |=> st_q.ser_sel == $past(ser_wdata_i))
        else $error("source select not stored");
    AST_SER_READ: assert property (ser_addr_i == `SER_SOURCE_OFS
        |=> ser_rdata_o == $past(st_q.ser_sel))
        else $error("source select read back wrong");
    AST_SER_UNMAPPED: assert property (!(ser_addr_i inside {`SER_SETPOINT_OFS, `SER_SOURCE_OFS, `PID_MON_OFS})
        |=> ser_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    AST_CTR_WRAP: assert property (st_q.tick |-> st_q.ctr == 24'h000000)
        else $error("sample counter not restarted at tick");
    AST_CTR_STEP: assert property (!tick_c |=> st_q.ctr == $past(st_q.ctr) + 24'h000001)
        else $error("sample counter skipped a cycle");

    COV_DIRECT: cover property (tick_c && cfg_i.mode == `MODE_DIRECT_DEV);
    COV_TRIM: cover property (tick_c && cfg_i.mode == `MODE_TRIM_FB);
    COV_CFG_ERR: cover property ($rose(st_q.cfg_err));
    COV_DIFF: cover property (tick_c && en_c && |dfb_src);
    COV_INT_CLAMP: cover property (tick_c && en_c && cfg_i.ti != 12'h000 && acc_n == acc_lim);

endmodule : pid_process_regulator

//--- bench/process_sensor_model.sv
// Behavioural process sensors feeding the analog and pulse inputs
`timescale 1ns/1ps

module process_sensor_model (
    // Sensor levels, 0.01 percent units
    output logic signed [15:0] analog_one_o,
    output logic signed [15:0] analog_two_o,
    output logic signed [15:0] pulse_rate_o
);
    initial
    begin
        analog_one_o = 16'sh0000;
        analog_two_o = 16'sh0000;
        pulse_rate_o = 16'sh0000;
    end

    // Sets all three sensor levels at once
    task automatic set_levels(input logic signed [15:0] a1, input logic signed [15:0] a2,
                              input logic signed [15:0] p);
        analog_one_o = a1;
        analog_two_o = a2;
        pulse_rate_o = p;
    endtask : set_levels
endmodule : process_sensor_model

//--- bench/testbench.sv
// Self-checking bench of the process regulator
`timescale 1ns/1ps
`include "pid_reg_defs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR t=%0t got %h expected %h", $time, (got), (exp)); end end

module testbench
    import pid_regulator_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic               clk_sys = 1'b0;
    logic               reset_n;
    pid_cfg_s           cfg;
    logic signed [15:0] freq_ref;
    logic signed [15:0] ain1;
    logic signed [15:0] ain2;
    logic signed [15:0] pulse_in;
    logic               ser_wr;
    logic        [7:0]  ser_addr;
    logic        [15:0] ser_wdata;
    logic        [15:0] ser_rdata;
    logic signed [15:0] pid_out;
    logic signed [15:0] freq_out;
    logic               done;
    logic               cfg_err;
    logic               diff_act;
    int                 n_mismatch = 0;
    int                 total_checks = 0;
    logic        [23:0] conflict_tbl [5] = '{24'h0C0C00, 24'h0B0B00, 24'h161600, 24'h0C0002, 24'h0B0001};

    always #20 clk_sys = ~clk_sys;

    process_sensor_model SENS (.analog_one_o(ain1), .analog_two_o(ain2), .pulse_rate_o(pulse_in));

    pid_process_regulator #(.SAMPLE_US(1)) DUT (
        .clk_sys_i               (clk_sys),
        .reset_n_i               (reset_n),
        .cfg_i                   (cfg),
        .freq_reference_i        (freq_ref),
        .analog_input_one_i      (ain1),
        .analog_input_two_i      (ain2),
        .pulse_train_input_i     (pulse_in),
        .ser_wr_i                (ser_wr),
        .ser_addr_i              (ser_addr),
        .ser_wdata_i             (ser_wdata),
        .ser_rdata_o             (ser_rdata),
        .pid_output_o            (pid_out),
        .freq_output_o           (freq_out),
        .sample_done_o           (done),
        .operator_config_error_o (cfg_err),
        .diff_feedback_active_o  (diff_act)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic final_report();
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic wait_done(input int n);
        int k;
        for (int i = 0; i < n; i++)
        begin
            k = 0;
            do
            begin
                @(posedge clk_sys);
                #1;
                k++;
            end while (done !== 1'b1 && k < 40);
            if (done !== 1'b1)
            begin
                n_mismatch++;
                $display("ERROR t=%0t no sample pulse", $time);
                final_report();
            end
        end
    endtask : wait_done

    task automatic run_chk(input int n, input logic signed [15:0] e_pid, input logic signed [15:0] e_freq,
                           input logic e_err, input logic e_diff);
        wait_done(n);
        `CHK(pid_out, e_pid)
        `CHK(freq_out, e_freq)
        `CHK(cfg_err, e_err)
        `CHK(diff_act, e_diff)
    endtask : run_chk

    task automatic ser_write(input logic [7:0] a, input logic [15:0] d);
        ser_addr = a;
        ser_wdata = d;
        ser_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        ser_wr = 1'b0;
    endtask : ser_write

    task automatic ser_read(input logic [7:0] a, input logic [15:0] e);
        ser_addr = a;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK(ser_rdata, e)
    endtask : ser_read

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        cfg = '0;
        cfg.kp = 12'h064;
        cfg.ilim = 10'h3E8;
        freq_ref = 16'sh0BB8;
        ser_wr = 1'b0;
        ser_addr = 8'h00;
        ser_wdata = 16'h0000;
        reset_n = 1'b0;
        repeat (12) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        `CHK(pid_out, 16'sh0000)
        `CHK(freq_out, 16'sh0000)
        ser_read(`SER_SETPOINT_OFS, 16'h0000);
        ser_read(`SER_SOURCE_OFS, 16'h0000);
        ser_write(`SER_SETPOINT_OFS, 16'h04D2);
        ser_read(`SER_SETPOINT_OFS, 16'h04D2);
        ser_read(8'h20, 16'h0000);
        SENS.set_levels(16'sh03E8, 16'sh01F4, 16'sh0320);
        cfg.ain1_fn = `FN_FEEDBACK;
        run_chk(2, 16'sh0000, 16'sh0BB8, 1'b0, 1'b0);
        wait_done(1);
        repeat (24) @(posedge clk_sys);
        #1;
        `CHK(done, 1'b0)
        @(posedge clk_sys);
        #1;
        `CHK(done, 1'b1)
        for (int m = 1; m <= 4; m++)
        begin
            cfg.mode = 3'(m);
            run_chk(2, (m < 3) ? 16'sh07D0 : -16'sh03E8, 16'sh07D0, 1'b0, 1'b0);
        end
        cfg.mode = `MODE_DIRECT_DEV;
        cfg.kp = 12'h0FA;
        run_chk(2, 16'sh1388, 16'sh1388, 1'b0, 1'b0);
        cfg.kp = 12'h064;
        cfg.mode = `MODE_TRIM_DEV;
        ser_write(`SER_SOURCE_OFS, 16'h0002);
        run_chk(2, 16'sh00EA, 16'sh0CA2, 1'b0, 1'b0);
        ser_write(`SER_SOURCE_OFS, 16'h0000);
        cfg.sp_param_sel = 1'b1;
        cfg.sp_param_val = 16'sh02BC;
        run_chk(2, -16'sh012C, 16'sh0A8C, 1'b0, 1'b0);
        cfg.sp_param_sel = 1'b0;
        cfg.ain2_fn = `FN_SETPOINT;
        run_chk(2, -16'sh01F4, 16'sh09C4, 1'b0, 1'b0);
        cfg.ain2_fn = 8'h00;
        cfg.pulse_fn = `PULSE_SETPOINT;
        run_chk(2, -16'sh00C8, 16'sh0AF0, 1'b0, 1'b0);
        cfg.pulse_fn = 8'h00;
        cfg.ain2_fn = `FN_DIFF_FB;
        run_chk(2, -16'sh01F4, 16'sh09C4, 1'b0, 1'b1);
        for (int i = 0; i < 5; i++)
        begin
            {cfg.ain1_fn, cfg.ain2_fn, cfg.pulse_fn} = conflict_tbl[i];
            repeat (2) @(posedge clk_sys);
            #1;
            `CHK(cfg_err, 1'b1)
        end
        {cfg.ain1_fn, cfg.ain2_fn, cfg.pulse_fn} = 24'h0B0000;
        cfg.mode = 3'h5;
        run_chk(2, 16'sh0000, 16'sh0BB8, 1'b1, 1'b0);
        cfg.mode = `MODE_OFF;
        run_chk(1, 16'sh0000, 16'sh0BB8, 1'b0, 1'b0);
        cfg.td = 10'h001;
        cfg.mode = `MODE_DIRECT_DEV;
        run_chk(1, 16'sh7FFF, 16'sh7FFF, 1'b0, 1'b0);
        run_chk(1, 16'sh07D0, 16'sh07D0, 1'b0, 1'b0);
        cfg.mode = `MODE_OFF;
        run_chk(1, 16'sh0000, 16'sh0BB8, 1'b0, 1'b0);
        cfg.mode = `MODE_DIRECT_FB;
        run_chk(1, 16'sh8000, 16'sh8000, 1'b0, 1'b0);
        cfg.td = 10'h000;
        cfg.kp = 12'h000;
        cfg.mode = `MODE_TRIM_DEV;
        run_chk(1, 16'sh0000, 16'sh0BB8, 1'b0, 1'b0);
        cfg.ti = 12'h001;
        cfg.ilim = 10'h001;
        cfg.sp_param_sel = 1'b1;
        cfg.sp_param_val = 16'sh7D00;
        SENS.set_levels(-16'sh7D00, 16'sh01F4, 16'sh0320);
        run_chk(2, 16'sh0001, 16'sh0BB9, 1'b0, 1'b0);
        run_chk(18, 16'sh000A, 16'sh0BC2, 1'b0, 1'b0);
        ser_read(`PID_MON_OFS, 16'h000A);
        reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        `CHK(pid_out, 16'sh0000)
        `CHK(freq_out, 16'sh0000)
        ser_read(`SER_SETPOINT_OFS, 16'h0000);
        run_chk(1, 16'sh0000, 16'sh0BB8, 1'b0, 1'b0);
        final_report();
    end
endmodule : testbench
